// >>> logic/ocmp_regs.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef OCMP_REGS_SVH
`define OCMP_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OCMP_OFF_COUNT      8'h00
`define OCMP_OFF_COMPARE    8'h04
`define OCMP_OFF_CTRL1      8'h08
`define OCMP_OFF_SRCSEL     8'h10
`define OCMP_OFF_PINIO      8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define OCMP_CTRL1_RUN      0
`define OCMP_CTRL1_STAT     1
`define OCMP_CTRL1_RST      2
`define OCMP_CTRL1_BUSY     3
`define OCMP_SRC_LSB        0
`define OCMP_SRC_PRE        2
`define OCMP_PINMODE_LSB    4
`define OCMP_CLKOUT_LSB     6
`define OCMP_PINIO_DATA     0
`define OCMP_PINIO_DIR      1
`define OCMP_PINIO_IN       2

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define OCMP_COMPARE_RST    8'h00
`define OCMP_SRCSEL_RST     8'h00
`define OCMP_PINIO_RST      2'h0
`define OCMP_PRE_LAST       4'hF
`define OCMP_LS_LAST        2'h3

`endif

// >>> logic/ocmp_pkg.sv
// Types shared by the output compare timer files.
package ocmp_pkg;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    OCMP_SRC_F4,
    OCMP_SRC_F8,
    OCMP_SRC_F32,
    OCMP_SRC_FC4
  } ocmp_src_t;

  typedef enum logic [1:0] {
    OCMP_PIN_GPIO,
    OCMP_PIN_CLK,
    OCMP_PIN_CMP
  } ocmp_pin_t;

  typedef enum logic [1:0] {
    OCMP_CLK_F2,
    OCMP_CLK_F4,
    OCMP_CLK_F8
  } ocmp_clk_t;

endpackage

// >>> logic/ocmp_clkdiv.sv
// Free-running divider giving rate enables and square levels of the clock.
module ocmp_clkdiv
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Rate enables, one cycle each
  output logic      en_f4,
  output logic      en_f8,
  output logic      en_f32,
  // Square levels for the pin
  output logic      lvl_f2,
  output logic      lvl_f4,
  output logic      lvl_f8
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [2:0] en_q;
  logic [2:0] en_d;

  always_comb
  begin
    cnt_d = cnt_q + 5'h01;
    en_d  = {cnt_d == 5'h00, cnt_d[2:0] == 3'h0, cnt_d[1:0] == 2'h0};
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt_q <= 5'h00;
      en_q  <= 3'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
      en_q  <= en_d;
    end
  end

  assign en_f4  = en_q[0];
  assign en_f8  = en_q[1];
  assign en_f32 = en_q[2];
  assign lvl_f2 = cnt_q[0];
  assign lvl_f4 = cnt_q[1];
  assign lvl_f8 = cnt_q[2];

endmodule // ocmp_clkdiv

// >>> logic/ocmp_timer.sv
// Output compare timer: register slave, count chain and compare pin.
// ****************************************************************
// Function
// - Source halved; compare on 8-bit counter only.
// - Sources f4, f8, f32, divided low-speed clock.
// - Counter increments, clears on match, continues.
// - Counter holds its value while stopped.
// - Period 2(n+1), or 32(n+1) with prescaler.
// - Run request 1 starts, 0 stops counting.
// - Interrupt request on every compare match.
// - Pin: general I/O, f2/f4/f8, or compare.
// - Readback gives counter; compare reads programmed value.
// - Counter writes ignored; compare writable only stopped.
// - Compare output inverts on every match.
// - Compare output low after any reset.
// - Stopping holds the compare output level.
// - Status follows request within two source cycles.
// - Stopped means request and status both zero.
// - Busy flag in clock mode; read after busy (here busy always reads 0).
// ****************************************************************
//
// The strobed register port and the register addresses were left to the implementer.
`include "ocmp_regs.svh"

module ocmp_timer
  import ocmp_pkg::*;
#(
  parameter bit HAS_LOW_SPEED = 1'b1
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Low-speed clock pin
  input  wire logic       low_speed_clk,
  // Compare output pin
  input  wire logic       compare_output_pin_in,
  output logic            compare_output_pin_out,
  output logic            compare_output_pin_oe,
  // Timer event
  output logic            timer_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] count_q,   count_d;
  logic [7:0] compare_q, compare_d;
  logic [7:0] srcsel_q,  srcsel_d;
  logic [1:0] pio_q,     pio_d;
  logic [3:0] pre_q,     pre_d;
  logic [1:0] ls_div_q,  ls_div_d;
  logic [7:0] rdata_q,   rdata_d;
  logic       run_req_q, run_req_d;
  logic       run_mid_q, run_mid_d;
  logic       run_stat_q, run_stat_d;
  logic       half_q,    half_d;
  logic       out_lvl_q, out_lvl_d;
  logic       irq_q,     irq_d;
  logic       pin_o_q,   pin_o_d;
  logic       pin_oe_q,  pin_oe_d;
  logic       ls_s1_q, ls_s2_q, ls_s3_q;
  logic       pin_s1_q, pin_s2_q;
  logic       en_f4, en_f8, en_f32;
  logic       lvl_f2, lvl_f4, lvl_f8;
  logic       src_tick;
  logic       fc4_tick;
  logic       advance;
  logic       match;
  logic       stopped;
  logic       wr_ctrl1;
  logic       timer_rst;
  ocmp_src_t  src_sel;
  ocmp_pin_t  pin_mode;
  ocmp_clk_t  clk_sel;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ****************************************************************
  // Rate enables
  // ****************************************************************
  ocmp_clkdiv u_clkdiv
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .en_f4   (en_f4),
    .en_f8   (en_f8),
    .en_f32  (en_f32),
    .lvl_f2  (lvl_f2),
    .lvl_f4  (lvl_f4),
    .lvl_f8  (lvl_f8)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    src_sel  = ocmp_src_t'(srcsel_q[`OCMP_SRC_LSB +: 2]);
    pin_mode = ocmp_pin_t'(srcsel_q[`OCMP_PINMODE_LSB +: 2]);
    clk_sel  = ocmp_clk_t'(srcsel_q[`OCMP_CLKOUT_LSB +: 2]);
    wr_ctrl1 = reg_wr && hit(reg_addr, `OCMP_OFF_CTRL1);
    timer_rst = wr_ctrl1 && reg_wdata[`OCMP_CTRL1_RST];
    stopped  = !run_req_q && !run_stat_q;
    // Low-speed edges are counted in fours; a variant without the pin
    // simply never ticks on that choice.
    fc4_tick = HAS_LOW_SPEED && ls_s2_q && !ls_s3_q
               && (ls_div_q == `OCMP_LS_LAST);
    ls_div_d = (ls_s2_q && !ls_s3_q) ? ls_div_q + 2'h1 : ls_div_q;
    unique case (src_sel)
      OCMP_SRC_F4:  src_tick = en_f4;
      OCMP_SRC_F8:  src_tick = en_f8;
      OCMP_SRC_F32: src_tick = en_f32;
      OCMP_SRC_FC4: src_tick = fc4_tick;
    endcase

    count_d    = count_q;
    compare_d  = compare_q;
    srcsel_d   = srcsel_q;
    pio_d      = pio_q;
    pre_d      = pre_q;
    half_d     = half_q;
    run_req_d  = run_req_q;
    run_mid_d  = run_mid_q;
    run_stat_d = run_stat_q;
    out_lvl_d  = out_lvl_q;
    advance    = 1'b0;
    match      = 1'b0;

    // The status flag moves only on source ticks or timer reset, two stages behind.
    if (src_tick)
    begin
      run_mid_d  = run_req_q;
      run_stat_d = run_mid_q;
    end

    // Counting rides on the status flag, so a stopped timer holds.
    if (src_tick && run_stat_q)
    begin
      half_d = !half_q;
      if (half_q)
      begin
        if (srcsel_q[`OCMP_SRC_PRE])
        begin
          pre_d   = pre_q + 4'h1;
          advance = (pre_q == `OCMP_PRE_LAST);
        end
        else
        begin
          advance = 1'b1;
        end
      end
    end

    if (advance)
    begin
      if (count_q == compare_q)
      begin
        count_d = 8'h00;
        match   = 1'b1;
      end
      else
      begin
        count_d = count_q + 8'h01;
      end
    end

    if (match)
    begin
      out_lvl_d = !out_lvl_q;
    end

    // Register writes; the counter readback offset takes no write.
    if (wr_ctrl1)
    begin
      run_req_d = reg_wdata[`OCMP_CTRL1_RUN];
    end
    if (reg_wr && hit(reg_addr, `OCMP_OFF_COMPARE) && stopped)
    begin
      compare_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `OCMP_OFF_SRCSEL))
    begin
      srcsel_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `OCMP_OFF_PINIO))
    begin
      pio_d = reg_wdata[1:0];
    end

    // Timer reset clears the chain and the pin level, setup is kept.
    if (timer_rst)
    begin
      count_d    = 8'h00;
      pre_d      = 4'h0;
      half_d     = 1'b0;
      run_req_d  = 1'b0;
      run_mid_d  = 1'b0;
      run_stat_d = 1'b0;
      out_lvl_d  = 1'b0;
    end

    irq_d = match;

    rdata_d = 8'h00;
    if (reg_rd)
    begin
      if (hit(reg_addr, `OCMP_OFF_COUNT))
        rdata_d = count_q;
      else if (hit(reg_addr, `OCMP_OFF_COMPARE))
        rdata_d = compare_q;
      else if (hit(reg_addr, `OCMP_OFF_CTRL1))
      begin
        rdata_d[`OCMP_CTRL1_RUN]  = run_req_q;
        rdata_d[`OCMP_CTRL1_STAT] = run_stat_q;
        rdata_d[`OCMP_CTRL1_BUSY] = 1'b0;
      end
      else if (hit(reg_addr, `OCMP_OFF_SRCSEL))
        rdata_d = srcsel_q;
      else if (hit(reg_addr, `OCMP_OFF_PINIO))
        rdata_d = {5'h00, pin_s2_q, pio_q};
    end

    // The pin holds its level when stopped because out_lvl_q does.
    unique case (pin_mode)
      OCMP_PIN_GPIO:
      begin
        pin_o_d  = pio_q[`OCMP_PINIO_DATA];
        pin_oe_d = pio_q[`OCMP_PINIO_DIR];
      end
      OCMP_PIN_CLK:
      begin
        pin_o_d  = (clk_sel == OCMP_CLK_F8) ? lvl_f8 :
                   (clk_sel == OCMP_CLK_F4) ? lvl_f4 : lvl_f2;
        pin_oe_d = 1'b1;
      end
      OCMP_PIN_CMP:
      begin
        pin_o_d  = out_lvl_q;
        pin_oe_d = 1'b1;
      end
      default:
      begin
        pin_o_d  = 1'b0;
        pin_oe_d = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      count_q    <= 8'h00;
      compare_q  <= `OCMP_COMPARE_RST;
      srcsel_q   <= `OCMP_SRCSEL_RST;
      pio_q      <= `OCMP_PINIO_RST;
      pre_q      <= 4'h0;
      ls_div_q   <= 2'h0;
      rdata_q    <= 8'h00;
      run_req_q  <= 1'b0;
      run_mid_q  <= 1'b0;
      run_stat_q <= 1'b0;
      half_q     <= 1'b0;
      out_lvl_q  <= 1'b0;
      irq_q      <= 1'b0;
      pin_o_q    <= 1'b0;
      pin_oe_q   <= 1'b0;
      ls_s1_q    <= 1'b0;
      ls_s2_q    <= 1'b0;
      ls_s3_q    <= 1'b0;
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
    end
    else
    begin
      count_q    <= count_d;
      compare_q  <= compare_d;
      srcsel_q   <= srcsel_d;
      pio_q      <= pio_d;
      pre_q      <= pre_d;
      ls_div_q   <= ls_div_d;
      rdata_q    <= rdata_d;
      run_req_q  <= run_req_d;
      run_mid_q  <= run_mid_d;
      run_stat_q <= run_stat_d;
      half_q     <= half_d;
      out_lvl_q  <= out_lvl_d;
      irq_q      <= irq_d;
      pin_o_q    <= pin_o_d;
      pin_oe_q   <= pin_oe_d;
      ls_s1_q    <= low_speed_clk;
      ls_s2_q    <= ls_s1_q;
      ls_s3_q    <= ls_s2_q;
      pin_s1_q   <= compare_output_pin_in;
      pin_s2_q   <= pin_s1_q;
    end
  end

  assign reg_rdata              = rdata_q;
  assign timer_irq              = irq_q;
  assign compare_output_pin_out = pin_o_q;
  assign compare_output_pin_oe  = pin_oe_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  property p_cmp_lock;
    reg_wr && hit(reg_addr, `OCMP_OFF_COMPARE) && !stopped
      |=> $stable(compare_q);
  endproperty
  a_cmp_lock: assert property (p_cmp_lock)
    else $error("compare value changed while running");

  property p_hold;
    !run_stat_q && !timer_rst |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while stopped");

  property p_wrap;
    irq_q |-> count_q == 8'h00 && $past(count_q) == $past(compare_q);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("match did not clear the counter");

  property p_toggle;
    irq_q |-> out_lvl_q != $past(out_lvl_q);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("compare level did not invert on match");

  property p_rst_low;
    timer_rst |=> !out_lvl_q && !run_stat_q && count_q == 8'h00;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("timer reset left output or counter set");

  property p_start;
    $rose(run_req_q) && src_sel != OCMP_SRC_FC4
      ##1 (run_req_q && $stable(srcsel_q)) [*8]
      |-> ##[0:60] run_stat_q;
  endproperty
  a_start: assert property (p_start)
    else $error("status did not follow start request");

  property p_stat_src;
    $changed(run_stat_q) |-> $past(src_tick) || $past(timer_rst);
  endproperty
  a_stat_src: assert property (p_stat_src)
    else $error("status flag moved off a source tick");

  property p_readback;
    reg_rd && hit(reg_addr, `OCMP_OFF_COUNT)
      |=> reg_rdata == $past(count_q);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback differs from counter");

  property p_pin_cmp;
    pin_mode == OCMP_PIN_CMP |=> compare_output_pin_out == $past(out_lvl_q)
      && compare_output_pin_oe;
  endproperty
  a_pin_cmp: assert property (p_pin_cmp)
    else $error("pin does not carry compare level");

  c_match: cover property (irq_q && pin_mode == OCMP_PIN_CMP);
  c_start: cover property ($rose(run_stat_q));
  c_stop:  cover property ($fell(run_stat_q) && count_q != 8'h00);
  c_pre:   cover property (irq_q && srcsel_q[`OCMP_SRC_PRE]);

endmodule // ocmp_timer

// >>> bench/output_compare_timer_tb_top.sv
// Self-checking testbench of the output compare timer.
`include "ocmp_regs.svh"

module output_compare_timer_tb_top
  import ocmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       clock;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       low_speed_clk;
  logic       ext_lvl;
  wire logic  pin_wire;
  logic       pin_out;
  logic       pin_oe;
  logic       timer_irq;
  int         n_mismatch;
  int         n_checks;
  int         cyc;
  logic [7:0] v;
  logic [7:0] v2;
  logic       p;
  int         tk [4] = '{4, 8, 32, 20};

  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ocmp_row_t;
  ocmp_row_t rows [7] = '{
    '{`OCMP_OFF_COMPARE, 8'h5A, 8'h5A},
    '{`OCMP_OFF_COMPARE, 8'h03, 8'h03},
    '{`OCMP_OFF_COUNT,   8'hFF, 8'h00},
    '{8'h0C,             8'hFF, 8'h00},
    '{`OCMP_OFF_PINIO,   8'h01, 8'h01},
    '{`OCMP_OFF_SRCSEL,  8'h96, 8'h96},
    '{`OCMP_OFF_CTRL1,   8'h02, 8'h00}};

  // The pin level is worked out from who drives it.
  assign pin_wire = pin_oe ? pin_out : ext_lvl;

  ocmp_timer uut
  (
    .clock                  (clock),
    .sys_rst                (sys_rst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .low_speed_clk          (low_speed_clk),
    .compare_output_pin_in  (pin_wire),
    .compare_output_pin_out (pin_out),
    .compare_output_pin_oe  (pin_oe),
    .timer_irq              (timer_irq)
  );

  // ****************************************************************
  // Clocks and hang guard
  // ****************************************************************
  always #20 clock = ~clock;

  // Offset so low-speed edges never meet a system clock edge.
  initial
  begin
    low_speed_clk = 1'b0;
    #7;
    forever #100 low_speed_clk = ~low_speed_clk;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_int(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Only the control register is polled while the status settles.
  task automatic run(input logic on, input int t);
    int t0;
    t0 = cyc;
    wr(`OCMP_OFF_CTRL1, {7'h00, on});
    do rd(`OCMP_OFF_CTRL1, v);
    while (v[1] !== on && cyc - t0 < 3 * t + 8);
    chk8(v, {6'h00, on, on});
  endtask

  task automatic wait_irq();
    do @(posedge clock);
    while (timer_irq !== 1'b1);
  endtask

  task automatic period(input int exp);
    int t0;
    wait_irq();
    t0 = cyc;
    repeat (2) @(posedge clock);
    p = pin_out;
    wait_irq();
    chk_int(cyc - t0, exp);
    repeat (2) @(posedge clock);
    chk8({7'h00, pin_out}, {7'h00, ~p});
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    clock = 1'b0; sys_rst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; ext_lvl = 1'b0; n_mismatch = 0;
    n_checks = 0; cyc = 0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk8(v, rows[i].e);
    end
    // A second reset must bring back the pin, compare, source select and control defaults.
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    chk8({5'h00, pin_out, pin_oe, timer_irq}, 8'h00);
    rd(`OCMP_OFF_COMPARE, v); chk8(v, 8'h00);
    rd(`OCMP_OFF_SRCSEL, v); chk8(v, 8'h00);
    rd(`OCMP_OFF_CTRL1, v); chk8(v, 8'h00);
    // Period of every source with compare value 3.
    wr(`OCMP_OFF_COMPARE, 8'h03);
    for (int s = 0; s < 4; s++)
    begin
      wr(`OCMP_OFF_SRCSEL, 8'h20 | s[7:0]);
      run(1'b1, tk[s]);
      period(8 * tk[s]);
      run(1'b0, tk[s]);
    end
    wr(`OCMP_OFF_SRCSEL, 8'h24);
    run(1'b1, 4);
    period(128 * 4);
    rd(`OCMP_OFF_COUNT, v);
    chk8({7'h00, v <= 8'h03}, 8'h01);
    wr(`OCMP_OFF_COMPARE, 8'h10);
    rd(`OCMP_OFF_COMPARE, v); chk8(v, 8'h03);
    // Stop in mid-count and check nothing moves.
    run(1'b0, 4);
    rd(`OCMP_OFF_COUNT, v);
    p = pin_out;
    repeat (300) @(posedge clock);
    rd(`OCMP_OFF_COUNT, v2); chk8(v2, v);
    chk8({7'h00, pin_out}, {7'h00, p});
    // Timer reset while running and the pin high.
    run(1'b1, 4);
    do
    begin
      wait_irq();
      repeat (2) @(posedge clock);
    end
    while (pin_out !== 1'b1);
    wr(`OCMP_OFF_CTRL1, 8'h05);
    repeat (2) @(posedge clock);
    chk8({7'h00, pin_out}, 8'h00);
    rd(`OCMP_OFF_COUNT, v); chk8(v, 8'h00);
    rd(`OCMP_OFF_CTRL1, v); chk8(v, 8'h00);
    // Clock outputs: f2, f4 and f8 give 64, 32 and 16 edges.
    for (int k = 0; k < 3; k++)
    begin
      int n;
      n = 0;
      wr(`OCMP_OFF_SRCSEL, 8'h10 | (k[7:0] << 6));
      repeat (4) @(posedge clock);
      // Start from a settled level so every step spans exactly one cycle.
      #1;
      repeat (64)
      begin
        p = pin_out;
        @(posedge clock);
        #1;
        n += (pin_out !== p);
      end
      chk_int(n, 64 >> k);
      chk8({7'h00, pin_oe}, 8'h01);
    end
    wr(`OCMP_OFF_SRCSEL, 8'h00);
    wr(`OCMP_OFF_PINIO, 8'h03);
    repeat (4) @(posedge clock);
    chk8({6'h00, pin_out, pin_oe}, 8'h03);
    rd(`OCMP_OFF_PINIO, v); chk8(v, 8'h07);
    // Pin mode three releases the pin and drives low.
    wr(`OCMP_OFF_SRCSEL, 8'h30);
    repeat (2) @(posedge clock);
    chk8({6'h00, pin_out, pin_oe}, 8'h00);
    tally_and_finish();
  end

endmodule // output_compare_timer_tb_top
